/* core/lpi_init.sv */
// Memory-side power-up and reset initialization sequencer with link-clock command capture.
`timescale 1ns/1ps
module lpi_init
    import lpi_pkg::*;
#(
    parameter int unsigned IDLE_CYC = IDLE_BEFORE_FIRST_MODE_ACCESS_CYC,
    parameter int unsigned CAL_CYC  = IMPEDANCE_CALIBRATION_TIME_CYC
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic                     ce,
    input  wire logic                     link_clk,
    input  wire logic                     reset_n,
    input  wire logic                     cke,
    input  wire logic                     cs,
    input  wire logic [lpi_pkg::CA_W-1:0] ca,
    output logic      [lpi_pkg::DQ_W-1:0] dq_out,
    output logic                          dq_oe,
    output logic      [lpi_pkg::DRV_W-1:0] drv_code,
    output logic                          boot_speed,
    output logic                          wrlev_active,
    output logic                          ready
);
    import lpi_pkg::*;

    localparam int unsigned CW = $clog2(IDLE_CYC + 1);

    // ==========================================================================
    // Link domain: command capture
    // ==========================================================================
    // Commands are registered on the link clock and handed over with a toggle.
    // The captured word stays still until the next command, so the controller
    // must space commands by more than the synchronizer latency.
    logic [CA_W-1:0] cmd_link_reg;
    logic [CA_W-1:0] cmd_link_next;
    logic            tog_link_reg;
    logic            tog_link_next;

    always_comb begin
        cmd_link_next = cmd_link_reg;
        tog_link_next = tog_link_reg;
        if (cke && cs) begin
            cmd_link_next = ca;
            tog_link_next = ~tog_link_reg;
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            cmd_link_reg <= '0;
            tog_link_reg <= 1'b0;
        end else begin
            cmd_link_reg <= cmd_link_next;
            tog_link_reg <= tog_link_next;
        end
    end

    // ==========================================================================
    // Crossings into the core domain
    // ==========================================================================
    logic            tog_s;
    logic            reset_n_s;
    logic            cke_s;
    logic [CA_W-1:0] ca_s;

    lpi_sync #(
        .W (1)
    ) u_tog_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .d        (tog_link_reg),
        .q        (tog_s)
    );

    // The bus word is synchronized bit by bit and may be caught mid-change for one cycle;
    // only the training echo reads it, and the controller holds each pattern far longer.
    lpi_sync #(
        .W (CA_W + 2)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .d        ({reset_n, cke, ca}),
        .q        ({reset_n_s, cke_s, ca_s})
    );

    logic tog_seen_reg;
    logic cmd_evt;

    assign cmd_evt = (tog_s != tog_seen_reg);

    // ==========================================================================
    // Calibration engine
    // ==========================================================================
    logic             zq_start;
    logic             zq_done;
    logic [DRV_W-1:0] zq_code;

    lpi_zq #(
        .CAL_CYC (CAL_CYC)
    ) u_zq (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .clear    (!reset_n_s),
        .start    (zq_start),
        .done     (zq_done),
        .code     (zq_code)
    );

    // ==========================================================================
    // Sequencer
    // ==========================================================================
    lpi_state_e       state_reg;
    lpi_state_e       state_next;
    logic [CW-1:0]    cnt_reg;
    logic [CW-1:0]    cnt_next;
    logic             cbt_done_reg;
    logic             cbt_done_next;
    logic             dq_trained_reg;
    logic             dq_trained_next;
    logic [DQ_W-1:0]  dq_out_next;
    logic             dq_oe_next;
    logic [DRV_W-1:0] drv_code_next;
    logic             wrlev_next;
    logic             ready_next;
    logic             boot_speed_next;

    always_comb begin
        state_next      = state_reg;
        cnt_next        = cnt_reg;
        cbt_done_next   = cbt_done_reg;
        dq_trained_next = dq_trained_reg;
        drv_code_next   = drv_code;
        wrlev_next      = wrlev_active;
        zq_start        = 1'b0;
        dq_out_next     = '0;
        unique case (state_reg)
            ST_RESET: begin
                state_next = ST_CKE_WAIT;
            end
            ST_CKE_WAIT: begin
                if (cke_s) begin
                    state_next = ST_IDLE_WAIT;
                    cnt_next   = '0;
                end
            end
            ST_IDLE_WAIT: begin
                // Commands arriving before the idle time has run out are dropped.
                if (cnt_reg == CW'(IDLE_CYC - 1)) begin
                    state_next = ST_BOOT;
                end else begin
                    cnt_next = cnt_reg + CW'(1);
                end
            end
            ST_BOOT: begin
                if (cmd_evt) begin
                    unique case (cmd_link_reg)
                        CMD_CBT_ENTER: begin
                            state_next = ST_CBT;
                        end
                        CMD_WRLEV_ON: begin
                            wrlev_next = 1'b1;
                            state_next = ST_WRLEV;
                        end
                        CMD_ZQ_START: begin
                            zq_start = 1'b1;
                        end
                        CMD_ZQ_LATCH: begin
                            if (zq_done) begin
                                drv_code_next = zq_code;
                            end
                        end
                        CMD_DQ_TRAINED: begin
                            dq_trained_next = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_CBT: begin
                // The echo is combinational in the part; here it trails the CA pins by the synchronizer and the output register.
                dq_out_next = DQ_W'(ca_s);
                if (cmd_evt && cmd_link_reg == CMD_CBT_EXIT) begin
                    cbt_done_next = 1'b1;
                    state_next    = ST_BOOT;
                    dq_out_next   = '0;
                end
            end
            ST_WRLEV: begin
                if (cmd_evt && cmd_link_reg == CMD_WRLEV_OFF) begin
                    wrlev_next = 1'b0;
                    state_next = ST_BOOT;
                end
            end
        endcase
        if (!reset_n_s) begin
            // Reset takes over from any state and releases every pin.
            state_next      = ST_RESET;
            cnt_next        = '0;
            cbt_done_next   = 1'b0;
            dq_trained_next = 1'b0;
            drv_code_next   = DRV_CODE_RESET;
            wrlev_next      = 1'b0;
            zq_start        = 1'b0;
            dq_out_next     = '0;
        end
        dq_oe_next      = (state_next == ST_CBT);
        ready_next      = (state_next == ST_BOOT);
        boot_speed_next = !cbt_done_next;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg      <= ST_RESET;
            cnt_reg        <= '0;
            cbt_done_reg   <= 1'b0;
            dq_trained_reg <= 1'b0;
            tog_seen_reg   <= 1'b0;
            dq_out         <= '0;
            dq_oe          <= 1'b0;
            drv_code       <= DRV_CODE_RESET;
            wrlev_active   <= 1'b0;
            ready          <= 1'b0;
            boot_speed     <= 1'b1;
        end else if (ce) begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            cbt_done_reg   <= cbt_done_next;
            dq_trained_reg <= dq_trained_next;
            tog_seen_reg   <= tog_s;
            dq_out         <= dq_out_next;
            dq_oe          <= dq_oe_next;
            drv_code       <= drv_code_next;
            wrlev_active   <= wrlev_next;
            ready          <= ready_next;
            boot_speed     <= boot_speed_next;
        end
    end

    // ==========================================================================
    // Checks
    // ==========================================================================
    a_reset_hiz: assert property (@(posedge core_clk) disable iff (rst)
        (ce && !reset_n_s) |=> (!dq_oe && dq_out == '0))
        else $error("Outputs driven while reset is held.");

    a_reset_state: assert property (@(posedge core_clk) disable iff (rst)
        (ce && !reset_n_s) |=> (state_reg == ST_RESET && !ready && !wrlev_active && drv_code == DRV_CODE_RESET))
        else $error("Reset did not force the reset state.");

    a_latch_apply: assert property (@(posedge core_clk) disable iff (rst)
        (ce && reset_n_s && state_reg == ST_BOOT && cmd_evt && cmd_link_reg == CMD_ZQ_LATCH && zq_done)
        |=> (drv_code == $past(zq_code)))
        else $error("Latch command did not apply the calibrated code.");

    // Boot speed may only be left on the cycle that closes command-bus training.
    a_boot_speed: assert property (@(posedge core_clk) disable iff (rst)
        (ce && boot_speed && !(state_reg == ST_CBT && state_next == ST_BOOT)) |=> boot_speed)
        else $error("High-speed mode before command-bus training.");

    a_cbt_echo: assert property (@(posedge core_clk) disable iff (rst)
        (ce && state_reg == ST_CBT && state_next == ST_CBT)
        |=> (dq_oe && dq_out == DQ_W'($past(ca_s))))
        else $error("Training pattern not echoed on DQ.");

    a_ready_boot: assert property (@(posedge core_clk) disable iff (rst)
        (ce && reset_n_s && state_reg == ST_BOOT && !cmd_evt) |=> ready)
        else $error("Not ready for commands after training.");

    // Commands are refused during the idle wait, so ready must not show early.
    a_idle_ready: assert property (@(posedge core_clk) disable iff (rst)
        (ce && reset_n_s && state_reg == ST_IDLE_WAIT && cnt_reg != CW'(IDLE_CYC - 1)) |=> !ready)
        else $error("Ready raised before the idle wait ran out.");

    // The trim code is a level: nothing but a latch command may move it outside reset.
    a_drv_hold: assert property (@(posedge core_clk) disable iff (rst)
        (ce && reset_n_s && !(cmd_evt && cmd_link_reg == CMD_ZQ_LATCH)) |=> $stable(drv_code))
        else $error("Trim code changed without a latch command.");

    a_latch_early: assert property (@(posedge core_clk) disable iff (rst)
        (ce && reset_n_s && cmd_evt && cmd_link_reg == CMD_ZQ_LATCH && !zq_done) |=> $stable(drv_code))
        else $error("Latch applied before calibration finished.");

    // Leaving training releases DQ and opens high-speed operation on the same edge.
    a_cbt_exit: assert property (@(posedge core_clk) disable iff (rst)
        (ce && reset_n_s && state_reg == ST_CBT && cmd_evt && cmd_link_reg == CMD_CBT_EXIT)
        |=> (!dq_oe && dq_out == '0 && ready && !boot_speed))
        else $error("Training exit left the bus driven.");

    a_oe_idle: assert property (@(posedge core_clk) disable iff (rst)
        (ce && reset_n_s && state_reg == ST_BOOT && !(cmd_evt && cmd_link_reg == CMD_CBT_ENTER)) |=> !dq_oe)
        else $error("DQ driven outside command-bus training.");

    // The training flags must not survive a warm reset, or boot speed would be skipped.
    a_train_clear: assert property (@(posedge core_clk) disable iff (rst)
        (ce && !reset_n_s) |=> (!cbt_done_reg && !dq_trained_reg))
        else $error("Reset left a training flag set.");

endmodule

/* core/lpi_pkg.sv */
// Constants, command codes and state type for the power-up initialization sequencer.
// Functional notes
// - While reset is held low, every memory output stays undriven; here DQ is released only after the synchronizer and a core-clock register.
// - After calibration time, latch command applies calibrated drive and termination values; here only the drive code drv_code is latched.
// - Memory starts in low-speed receiver mode until command-bus training completes.
// - In command-bus training, CA patterns are echoed on DQ without clock timing; here the echo passes the synchronizer and a core-clock register.
// - Once training is done the memory accepts any valid command.
// - Asserting reset forces the reset state from any operating state.
package lpi_pkg;

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int unsigned CORE_PERIOD_NS                   = 20;
    localparam int unsigned IDLE_BEFORE_FIRST_MODE_ACCESS_NS = 2000;
    localparam int unsigned IDLE_BEFORE_FIRST_MODE_ACCESS_CYC =
        (IDLE_BEFORE_FIRST_MODE_ACCESS_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int unsigned IMPEDANCE_CALIBRATION_TIME_NS    = 1000;
    localparam int unsigned IMPEDANCE_CALIBRATION_TIME_CYC   =
        (IMPEDANCE_CALIBRATION_TIME_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int unsigned SYNC_STAGES                      = 2;

    // ==========================================================================
    // Widths and reset values
    // ==========================================================================
    localparam int unsigned CA_W           = 6;
    localparam int unsigned DQ_W           = 16;
    localparam int unsigned DRV_W          = 8;
    localparam logic [7:0]  DRV_CODE_RESET = 8'h00;
    localparam logic [7:0]  DRV_CODE_CAL   = 8'h5A;
    localparam int unsigned WRLEV_BIT      = 7;

    // ==========================================================================
    // Command codes on the CA bus
    // ==========================================================================
    localparam logic [5:0] CMD_CBT_ENTER   = 6'h01;
    localparam logic [5:0] CMD_CBT_EXIT    = 6'h02;
    localparam logic [5:0] CMD_WRLEV_ON    = 6'h03;
    localparam logic [5:0] CMD_WRLEV_OFF   = 6'h04;
    localparam logic [5:0] CMD_ZQ_START    = 6'h05;
    localparam logic [5:0] CMD_ZQ_LATCH    = 6'h06;
    localparam logic [5:0] CMD_DQ_TRAINED  = 6'h07;

    typedef enum logic [2:0] {
        ST_RESET,
        ST_CKE_WAIT,
        ST_IDLE_WAIT,
        ST_BOOT,
        ST_CBT,
        ST_WRLEV
    } lpi_state_e;

endpackage

/* core/lpi_sync.sv */
// Two-stage synchronizer for a bundle of independent levels.
`timescale 1ns/1ps
module lpi_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_next;

    always_comb begin
        meta_next = ce ? d : meta_reg;
        q_next    = ce ? meta_reg : q;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= meta_next;
            q        <= q_next;
        end
    end
endmodule

/* core/lpi_zq.sv */
// Impedance calibration engine: runs for the calibration time after a start pulse.
`timescale 1ns/1ps
module lpi_zq
    import lpi_pkg::*;
#(
    parameter int unsigned CAL_CYC = IMPEDANCE_CALIBRATION_TIME_CYC
) (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire logic                clear,
    input  wire logic                start,
    output logic                     done,
    output logic [lpi_pkg::DRV_W-1:0] code
);
    localparam int unsigned CW = $clog2(CAL_CYC + 1);

    logic          busy_reg;
    logic          busy_next;
    logic          done_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    always_comb begin
        busy_next = busy_reg;
        done_next = done;
        cnt_next  = cnt_reg;
        if (clear) begin
            busy_next = 1'b0;
            done_next = 1'b0;
            cnt_next  = '0;
        end else if (start) begin
            busy_next = 1'b1;
            done_next = 1'b0;
            cnt_next  = '0;
        end else if (busy_reg) begin
            if (cnt_reg == CW'(CAL_CYC - 1)) begin
                busy_next = 1'b0;
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + CW'(1);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
            done     <= 1'b0;
            cnt_reg  <= '0;
        end else if (ce) begin
            busy_reg <= busy_next;
            done     <= done_next;
            cnt_reg  <= cnt_next;
        end
    end

    // Result is a fixed trim code in this model; a real engine compares against the resistor.
    assign code = DRV_CODE_CAL;
endmodule

/* bench/lpi_ctrl_model.sv */
// Behavioural memory-controller model driving reset, clock enable, chip select and commands.
`timescale 1ns/1ps
module lpi_ctrl_model #(
    parameter int unsigned CKE_LOW_CYC = 20
) (
    output logic                     link_clk,
    output logic                     reset_n,
    output logic                     cke,
    output logic                     cs,
    output logic [lpi_pkg::CA_W-1:0] ca
);
    import lpi_pkg::*;

    // ==========================================================================
    // Link clock
    // ==========================================================================
    // The clock runs through the whole boot, so it is stable long before clock-enable rises.
    initial begin
        link_clk = 1'b0;
        forever #6 link_clk = ~link_clk;
    end

    initial begin
        reset_n = 1'b0;
        cke     = 1'b0;
        cs      = 1'b0;
        ca      = 6'h2A;
    end

    // ==========================================================================
    // Sequences
    // ==========================================================================
    task automatic link_wait(input int n);
        repeat (n) @(negedge link_clk);
    endtask

    // Clock-enable drops with reset, so it is low far longer than needed before the release.
    // The enable wait after release is cut short to keep the run brief; the sequencer does not time it.
    task automatic start_up(input int hold_cyc);
        @(negedge link_clk);
        cke     = 1'b0;
        cs      = 1'b0;
        reset_n = 1'b0;
        link_wait(hold_cyc);
        reset_n = 1'b1;
        link_wait(CKE_LOW_CYC);
        cke = 1'b1;
    endtask

    // The bus shows the inverse code once deselected, so a stale value is never mistaken for data.
    task automatic send_cmd(input logic [CA_W-1:0] code);
        @(negedge link_clk);
        cs = 1'b1;
        ca = code;
        @(negedge link_clk);
        cs = 1'b0;
        ca = ~code;
        link_wait(8);
    endtask

    task automatic set_ca(input logic [CA_W-1:0] v);
        @(negedge link_clk);
        ca = v;
    endtask
endmodule

/* bench/sdram_power_up_init_sequence_test.sv */
// Self-checking testbench for the power-up initialization sequencer.
`timescale 1ns/1ps
module sdram_power_up_init_sequence_test;
    import lpi_pkg::*;

    localparam int unsigned IDLE_T    = 4;
    localparam int unsigned CAL_T     = 3;
    localparam int          HOLD_LINK = 16667;

    logic              core_clk;
    logic              rst;
    logic              ce;
    logic              link_clk;
    logic              reset_n;
    logic              cke;
    logic              cs;
    logic [CA_W-1:0]   ca;
    logic [DQ_W-1:0]   dq_out;
    logic              dq_oe;
    logic [DRV_W-1:0]  drv_code;
    logic              boot_speed;
    logic              wrlev_active;
    logic              ready;
    int                bad_count;
    int                checks;
    logic [CA_W-1:0]   pats [3] = '{6'h15, 6'h2A, 6'h3F};

    lpi_init #(.IDLE_CYC(IDLE_T), .CAL_CYC(CAL_T)) lpi_init_inst (
        .core_clk(core_clk), .rst(rst), .ce(ce), .link_clk(link_clk), .reset_n(reset_n),
        .cke(cke), .cs(cs), .ca(ca), .dq_out(dq_out), .dq_oe(dq_oe), .drv_code(drv_code),
        .boot_speed(boot_speed), .wrlev_active(wrlev_active), .ready(ready)
    );

    lpi_ctrl_model lpi_ctrl_model_inst (
        .link_clk(link_clk), .reset_n(reset_n), .cke(cke), .cs(cs), .ca(ca)
    );

    // ==========================================================================
    // Helpers
    // ==========================================================================
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic core_wait(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Commands are only sent once ready shows the idle wait is over.
    task automatic boot_up(input int hold);
        int n;
        lpi_ctrl_model_inst.start_up(hold);
        core_wait(3);
        check(16'(ready), 16'h0000);
        n = 0;
        while (ready !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        check(16'(ready), 16'h0001);
    endtask

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic test_power_up();
        check(16'(dq_oe), 16'h0000);
        check(dq_out, 16'h0000);
        check(16'(boot_speed), 16'h0001);
        check(16'(drv_code), 16'(DRV_CODE_RESET));
        boot_up(HOLD_LINK);
        check(16'(dq_oe), 16'h0000);
        $display("test power_up done");
    endtask

    task automatic test_zq();
        lpi_ctrl_model_inst.send_cmd(CMD_ZQ_LATCH);
        core_wait(8);
        check(16'(drv_code), 16'(DRV_CODE_RESET));
        lpi_ctrl_model_inst.send_cmd(CMD_ZQ_START);
        core_wait(CAL_T + 4);
        check(16'(drv_code), 16'(DRV_CODE_RESET));
        lpi_ctrl_model_inst.send_cmd(CMD_ZQ_LATCH);
        core_wait(8);
        check(16'(drv_code), 16'(DRV_CODE_CAL));
        $display("test zq done");
    endtask

    task automatic test_cbt();
        lpi_ctrl_model_inst.send_cmd(CMD_CBT_ENTER);
        core_wait(8);
        check(16'(dq_oe), 16'h0001);
        check(16'(ready), 16'h0000);
        check(16'(boot_speed), 16'h0001);
        for (int i = 0; i < 3; i++) begin
            lpi_ctrl_model_inst.set_ca(pats[i]);
            core_wait(6);
            check(dq_out, {10'h000, pats[i]});
        end
        lpi_ctrl_model_inst.send_cmd(CMD_CBT_EXIT);
        core_wait(8);
        check(16'(dq_oe), 16'h0000);
        check(dq_out, 16'h0000);
        check(16'(boot_speed), 16'h0000);
        check(16'(ready), 16'h0001);
        $display("test cbt done");
    endtask

    // With the enable low the core holds still; the captured command waits in the link toggle.
    task automatic test_freeze();
        ce = 1'b0;
        lpi_ctrl_model_inst.send_cmd(CMD_WRLEV_ON);
        core_wait(8);
        check(16'(wrlev_active), 16'h0000);
        check(16'(ready), 16'h0001);
        ce = 1'b1;
        core_wait(8);
        check(16'(wrlev_active), 16'h0001);
        check(16'(ready), 16'h0000);
        lpi_ctrl_model_inst.send_cmd(CMD_WRLEV_OFF);
        core_wait(8);
        check(16'(wrlev_active), 16'h0000);
        $display("test freeze done");
    endtask

    task automatic test_wrlev();
        lpi_ctrl_model_inst.send_cmd(CMD_WRLEV_ON);
        core_wait(8);
        check(16'(wrlev_active), 16'h0001);
        check(16'(ready), 16'h0000);
        lpi_ctrl_model_inst.send_cmd(CMD_WRLEV_OFF);
        core_wait(8);
        check(16'(wrlev_active), 16'h0000);
        lpi_ctrl_model_inst.send_cmd(CMD_DQ_TRAINED);
        core_wait(8);
        check(16'(ready), 16'h0001);
        check(16'(drv_code), 16'(DRV_CODE_CAL));
        $display("test wrlev done");
    endtask

    // A short warm reset taken in mid-training must still clear everything.
    task automatic test_warm_reset();
        lpi_ctrl_model_inst.send_cmd(CMD_CBT_ENTER);
        core_wait(8);
        check(16'(dq_oe), 16'h0001);
        boot_up(9);
        check(16'(dq_oe), 16'h0000);
        check(16'(drv_code), 16'(DRV_CODE_RESET));
        check(16'(boot_speed), 16'h0001);
        check(16'(wrlev_active), 16'h0000);
        $display("test warm_reset done");
    endtask

    // ==========================================================================
    // Main sequence and watchdog
    // ==========================================================================
    initial begin
        bad_count = 0;
        checks    = 0;
        ce        = 1'b1;
        rst       = 1'b1;
        core_wait(20);
        rst = 1'b0;
        test_power_up();
        test_zq();
        test_cbt();
        test_freeze();
        test_wrlev();
        test_warm_reset();
        wrap_up();
    end

    // The long reset hold dominates the run at about 200 us; five times that means a hang.
    initial begin
        #1000000;
        bad_count++;
        $display("watchdog expired at %0t", $time);
        wrap_up();
    end
endmodule
